// *** hw/analog_compare_cfg.svh ***
// Offsets, field positions and reset values of the analog compare block
`ifndef ANALOG_COMPARE_CFG_SVH
`define ANALOG_COMPARE_CFG_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_STATUS_CONTROL 12'h000
`define OFS_IRQ_STATUS 12'h004
`define OFS_IRQ_CLEAR 12'h008
`define OFS_IRQ_ENABLE 12'h00C
// ----------------------------------------------------------------------
// Field positions of the status and control register
// ----------------------------------------------------------------------
`define BIT_BLOCK_ENABLE 7
`define BIT_REFERENCE_SELECT 6
`define BIT_EVENT_FLAG 5
`define BIT_EVENT_IRQ_ENABLE 4
`define BIT_LIVE_OUTPUT 3
`define BIT_OUTPUT_PIN_ENABLE 2
`define BIT_EDGE_SELECT_HI 1
`define BIT_EDGE_SELECT_LO 0
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CONTROL 8'h00
`define RST_IRQ_ENABLE 1'h0
`endif

// *** hw/analog_compare_pkg.sv ***
// Types shared by the analog compare block
package analog_compare_pkg;
    typedef enum logic [1:0] {
        EDGE_FALL_A = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL_B = 2'b10,
        EDGE_ANY = 2'b11
    } edge_sel_e;

    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_WAIT = 2'b01,
        PM_MID_STOP = 2'b10,
        PM_DEEP_STOP = 2'b11
    } power_mode_e;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic block_enable;
        logic reference_select;
        logic event_irq_enable;
        logic output_pin_enable;
        edge_sel_e event_edge_select;
    } control_s;

    typedef struct packed {
        logic bandgap_select;
        logic low_power;
        logic compare_output;
        logic compare_output_oe;
    } analog_s;

    typedef struct packed {
        control_s ctrl;
        logic compare_event_flag;
        logic irq_enable;
        logic [2:0] sync;
        logic live;
        logic prev_valid;
        logic [31:0] prdata;
    } state_s;
endpackage

// *** hw/analog_compare_ctrl.sv ***
// Control and status logic around an analog voltage comparator
`timescale 1ns/100ps
// How it works
// (R1) Enable bit 7 turns the block on; compare logic past the synchroniser idles when 0.
// (R2) Bit 6 picks positive pin (0) or internal bandgap (1) as reference.
// (R3) Bit 5 flag set by selected edge, cleared by writing one.
// (R4) Bit 4 enables the interrupt request while the flag is set.
// (R5) Bit 3 reads the live comparator output, zero while disabled.
// (R6) Bit 2 drives the comparator output onto the output pin.
// (R7) Bits 1:0 pick falling (00,10), rising (01) or either (11) edge.
// (R8) Output high when non-inverting input exceeds inverting input.
// (R9) Block keeps comparing in wait and its interrupt can wake.
// (R10) Any stop mode disables the block; it never wakes from stop.
// (R11) Deep stop powers down; waking leaves everything at reset values.
// (R12) Mid stop holds registers, comparator low power, no events.
// (R13) Mid stop exit by reset resets; by interrupt resumes held state.
// (R14) Background debug halt changes nothing; block runs as normal.
// (R15) Control and status sit in one 8-bit register; flag and a second irq enable also have their own offsets.
// (R16) Software enables the bandgap buffer before selecting the bandgap.
// (R17) Output synchronised through flip-flops before edge detection.
`include "analog_compare_cfg.svh"

module analog_compare_ctrl (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire analog_compare_pkg::apb_req_s apb_req,
    output analog_compare_pkg::apb_rsp_s apb_rsp,
    // Power mode from the system
    input wire analog_compare_pkg::power_mode_e power_mode,
    // Analog comparator circuit
    input wire logic comparator_raw,
    output analog_compare_pkg::analog_s analog,
    // Interrupt
    output logic irq
);
    import analog_compare_pkg::*;

    state_s s_q;
    state_s s_d;
    logic active;
    logic rise;
    logic fall;
    logic edge_hit;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [7:0] sc_view;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic edge_match(edge_sel_e sel, logic r, logic f);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            EDGE_FALL_A, EDGE_FALL_B: hit = f; // [R7]
            EDGE_RISE: hit = r; // [R7]
            EDGE_ANY: hit = r | f; // [R7]
        endcase
        return hit;
    endfunction

    function automatic logic is_stop(power_mode_e m);
        return (m == PM_MID_STOP) || (m == PM_DEEP_STOP);
    endfunction

    // ------------------------------------------------------------------
    // Comparison path
    // ------------------------------------------------------------------
    // Stop forces the block off; wait and debug halt leave it running
    assign active = s_q.ctrl.block_enable && !is_stop(power_mode); // [R1] [R9] [R10] [R14]
    // Stages 1 and 2 must agree; stage 0 feeds stage 1 only
    assign rise = active && s_q.prev_valid && s_q.sync[1] && s_q.sync[2] && !s_q.live; // [R17]
    assign fall = active && s_q.prev_valid && !s_q.sync[1] && !s_q.sync[2] && s_q.live; // [R17]
    assign edge_hit = edge_match(s_q.ctrl.event_edge_select, rise, fall); // [R3]

    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign mapped = (apb_req.paddr == `OFS_STATUS_CONTROL) || (apb_req.paddr == `OFS_IRQ_STATUS)
        || (apb_req.paddr == `OFS_IRQ_CLEAR) || (apb_req.paddr == `OFS_IRQ_ENABLE);

    always_comb begin
        sc_view = 8'h00;
        sc_view[`BIT_BLOCK_ENABLE] = s_q.ctrl.block_enable;
        sc_view[`BIT_REFERENCE_SELECT] = s_q.ctrl.reference_select;
        sc_view[`BIT_EVENT_FLAG] = s_q.compare_event_flag;
        sc_view[`BIT_EVENT_IRQ_ENABLE] = s_q.ctrl.event_irq_enable;
        sc_view[`BIT_LIVE_OUTPUT] = s_q.live; // [R5]
        sc_view[`BIT_OUTPUT_PIN_ENABLE] = s_q.ctrl.output_pin_enable;
        sc_view[`BIT_EDGE_SELECT_HI:`BIT_EDGE_SELECT_LO] = s_q.ctrl.event_edge_select;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Synchroniser keeps running; only its use is gated
        s_d.sync = {s_q.sync[1:0], comparator_raw}; // [R8] [R17]
        if (active) begin
            s_d.live = s_q.sync[2]; // [R5]
            s_d.prev_valid = 1'b1;
        end else if (!is_stop(power_mode)) begin
            s_d.live = 1'b0; // [R5]
            s_d.prev_valid = 1'b0;
        end else begin
            // Mid stop: hold the live bit, detect nothing
            s_d.prev_valid = 1'b0; // [R12] [R13]
        end
        if (wr_acc && apb_req.paddr == `OFS_STATUS_CONTROL) begin
            s_d.ctrl.block_enable = apb_req.pwdata[`BIT_BLOCK_ENABLE]; // [R1]
            s_d.ctrl.reference_select = apb_req.pwdata[`BIT_REFERENCE_SELECT]; // [R2]
            s_d.ctrl.event_irq_enable = apb_req.pwdata[`BIT_EVENT_IRQ_ENABLE]; // [R4]
            s_d.ctrl.output_pin_enable = apb_req.pwdata[`BIT_OUTPUT_PIN_ENABLE]; // [R6]
            s_d.ctrl.event_edge_select =
                edge_sel_e'(apb_req.pwdata[`BIT_EDGE_SELECT_HI:`BIT_EDGE_SELECT_LO]); // [R7]
        end
        if (wr_acc && apb_req.paddr == `OFS_IRQ_ENABLE) begin
            s_d.irq_enable = apb_req.pwdata[0];
        end
        // Write one clears from either view; the set below wins
        if (wr_acc && ((apb_req.paddr == `OFS_STATUS_CONTROL && apb_req.pwdata[`BIT_EVENT_FLAG])
                || (apb_req.paddr == `OFS_IRQ_CLEAR && apb_req.pwdata[0]))) begin
            s_d.compare_event_flag = 1'b0; // [R3]
        end
        if (edge_hit) begin
            s_d.compare_event_flag = 1'b1; // [R3]
        end
        // Read data captured in setup so it is stable through access
        if (rd_acc) begin
            unique case (apb_req.paddr)
                `OFS_STATUS_CONTROL: s_d.prdata = {24'h000000, sc_view}; // [R15]
                `OFS_IRQ_STATUS: s_d.prdata = {31'h00000000, s_q.compare_event_flag};
                `OFS_IRQ_ENABLE: s_d.prdata = {31'h00000000, s_q.irq_enable};
                default: s_d.prdata = 32'h00000000;
            endcase
        end
    end

    // Deep stop is a power-down: the block comes back at reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else if (power_mode == PM_DEEP_STOP) begin
            s_q <= '0; // [R11]
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign apb_rsp.prdata = s_q.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
    assign analog.bandgap_select = s_q.ctrl.reference_select; // [R2] [R16]
    assign analog.low_power = !active; // [R12]
    assign analog.compare_output = s_q.live; // [R6]
    assign analog.compare_output_oe = active && s_q.ctrl.output_pin_enable; // [R6]
    // Stop masks the request so the block never wakes from stop
    assign irq = !is_stop(power_mode) && ((s_q.ctrl.event_irq_enable && s_q.compare_event_flag)
        || (s_q.irq_enable && s_q.compare_event_flag)); // [R4] [R9] [R10]

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Deep stop wipes state, so most checks exclude it
    logic ctrl_wr;
    logic keep_state;
    assign ctrl_wr = wr_acc && (apb_req.paddr == `OFS_STATUS_CONTROL);
    assign keep_state = (power_mode != PM_DEEP_STOP);

    // ------------------------------------------------------------------
    // Checks on enable, live bit and pin
    // ------------------------------------------------------------------
    a_live_zero_off: assert property ( // [R5]
        !s_q.ctrl.block_enable && !is_stop(power_mode) |=> !s_q.live)
        else $error("live output not zero while off");

    a_no_event_off: assert property ( // [R1]
        !s_q.ctrl.block_enable |-> !edge_hit)
        else $error("event while disabled");

    a_oe_follows: assert property ( // [R6]
        analog.compare_output_oe |-> s_q.ctrl.output_pin_enable)
        else $error("pin driven without enable");

    a_oe_off_inactive: assert property ( // [R6]
        !active |-> !analog.compare_output_oe)
        else $error("pin driven while inactive");

    a_live_is_sync: assert property ( // [R5]
        active |=> s_q.live == $past(s_q.sync[2]))
        else $error("live bit not from last stage");

    a_sync_shift: assert property ( // [R17]
        keep_state |=> s_q.sync[2:1] == $past(s_q.sync[1:0]))
        else $error("synchroniser did not shift");

    a_sync_delay: assert property ( // [R17]
        active && $past(active, 4) && $stable(comparator_raw)[*4]
        |-> s_q.live == $past(comparator_raw, 4))
        else $error("sync delay wrong");

    // ------------------------------------------------------------------
    // Checks on events, flag and interrupt
    // ------------------------------------------------------------------
    a_irq_follows_flag: assert property ( // [R4]
        s_q.ctrl.event_irq_enable && s_q.compare_event_flag && !is_stop(power_mode) |-> irq)
        else $error("irq missing");

    a_no_irq_disabled: assert property ( // [R4]
        !s_q.ctrl.event_irq_enable && !s_q.irq_enable |-> !irq)
        else $error("irq without enable");

    a_edge_sets_flag: assert property ( // [R3]
        edge_hit && !is_stop(power_mode) |=> s_q.compare_event_flag)
        else $error("event lost");

    a_zero_write_keeps: assert property ( // [R3]
        s_q.compare_event_flag && ctrl_wr && !apb_req.pwdata[`BIT_EVENT_FLAG] && keep_state
        |=> s_q.compare_event_flag)
        else $error("zero write cleared flag");

    a_flag_rise_cause: assert property ( // [R3]
        $rose(s_q.compare_event_flag) |-> $past(edge_hit))
        else $error("flag set without event");

    a_flag_fall_cause: assert property ( // [R3]
        $fell(s_q.compare_event_flag) |-> $past(wr_acc) || $past(power_mode == PM_DEEP_STOP))
        else $error("flag cleared without write");

    a_rise_only: assert property ( // [R7]
        s_q.ctrl.event_edge_select == EDGE_RISE && fall |-> !edge_hit)
        else $error("falling edge in rise mode");

    a_rise_hit: assert property ( // [R7]
        s_q.ctrl.event_edge_select == EDGE_RISE && rise |-> edge_hit)
        else $error("rising edge missed");

    a_fall_only: assert property ( // [R7]
        (s_q.ctrl.event_edge_select == EDGE_FALL_A || s_q.ctrl.event_edge_select == EDGE_FALL_B)
        && rise |-> !edge_hit)
        else $error("rising edge in fall mode");

    a_any_edge: assert property ( // [R7]
        s_q.ctrl.event_edge_select == EDGE_ANY && (rise || fall) |-> edge_hit)
        else $error("edge missed in either mode");

    a_first_active_quiet: assert property ( // [R13]
        active && !$past(active) |-> !edge_hit)
        else $error("edge on first active cycle");

    // ------------------------------------------------------------------
    // Checks on power modes
    // ------------------------------------------------------------------
    a_stop_no_irq: assert property ( // [R10]
        is_stop(power_mode) |-> !irq && !edge_hit)
        else $error("activity in stop");

    a_deep_stop_clear: assert property ( // [R11]
        power_mode == PM_DEEP_STOP |=> s_q == '0)
        else $error("deep stop kept state");

    a_mid_stop_hold: assert property ( // [R12]
        power_mode == PM_MID_STOP ##1 power_mode == PM_MID_STOP
        |-> $stable(s_q.ctrl) && $stable(s_q.compare_event_flag))
        else $error("mid stop changed state");

    a_live_held_mid: assert property ( // [R12]
        power_mode == PM_MID_STOP |=> s_q.live == $past(s_q.live))
        else $error("live bit moved in mid stop");

    a_low_power_stop: assert property ( // [R12]
        is_stop(power_mode) |-> analog.low_power)
        else $error("comparator awake in stop");

    a_wait_irq: assert property ( // [R9]
        power_mode == PM_WAIT && s_q.ctrl.event_irq_enable && s_q.compare_event_flag |-> irq)
        else $error("no wake request in wait");

    // ------------------------------------------------------------------
    // Checks on register access
    // ------------------------------------------------------------------
    a_enable_write: assert property ( // [R1]
        ctrl_wr && keep_state
        |=> s_q.ctrl.block_enable == $past(apb_req.pwdata[`BIT_BLOCK_ENABLE]))
        else $error("enable bit not written");

    a_ref_write: assert property ( // [R2]
        ctrl_wr && keep_state
        |=> s_q.ctrl.reference_select == $past(apb_req.pwdata[`BIT_REFERENCE_SELECT]))
        else $error("reference bit not written");

    a_ie_write: assert property ( // [R4]
        ctrl_wr && keep_state
        |=> s_q.ctrl.event_irq_enable == $past(apb_req.pwdata[`BIT_EVENT_IRQ_ENABLE]))
        else $error("irq enable bit not written");

    a_pin_en_write: assert property ( // [R6]
        ctrl_wr && keep_state
        |=> s_q.ctrl.output_pin_enable == $past(apb_req.pwdata[`BIT_OUTPUT_PIN_ENABLE]))
        else $error("pin enable bit not written");

    a_edge_write: assert property ( // [R7]
        ctrl_wr && keep_state
        |=> s_q.ctrl.event_edge_select == $past(apb_req.pwdata[1:0]))
        else $error("edge mode not written");

    a_ctrl_holds: assert property ( // [R15]
        !ctrl_wr && keep_state |=> $stable(s_q.ctrl))
        else $error("control changed without write");

    a_read_upper_zero: assert property ( // [R15]
        rd_acc && apb_req.paddr == `OFS_STATUS_CONTROL && keep_state
        |=> apb_rsp.prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    a_read_status_bit: assert property ( // [R3]
        rd_acc && apb_req.paddr == `OFS_IRQ_STATUS && keep_state
        |=> apb_rsp.prdata == {31'h00000000, $past(s_q.compare_event_flag)})
        else $error("status read wrong");

    a_read_unmapped: assert property ( // [R15]
        rd_acc && !mapped && keep_state |=> apb_rsp.prdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_prdata_holds: assert property ( // [R15]
        !rd_acc && keep_state |=> $stable(apb_rsp.prdata))
        else $error("read data moved");

    a_slverr_unmapped: assert property ( // [R15]
        apb_req.psel && apb_req.penable && !mapped |-> apb_rsp.pslverr)
        else $error("no error on unmapped access");

    a_slverr_mapped: assert property ( // [R15]
        apb_req.psel && apb_req.penable && mapped |-> !apb_rsp.pslverr)
        else $error("error on mapped access");

    // ------------------------------------------------------------------
    // Covers
    // ------------------------------------------------------------------
    c_rise_event: cover property (rise && edge_hit);
    c_fall_event: cover property (fall && edge_hit);
    c_irq_in_wait: cover property (irq && power_mode == PM_WAIT);
    c_clear_flag: cover property (s_q.compare_event_flag ##1 !s_q.compare_event_flag);
    c_mid_stop_resume: cover property (power_mode == PM_MID_STOP ##1 power_mode == PM_RUN);
endmodule

// *** sim/comparator_model.sv ***
// Behavioural model of the comparator circuit and its analog pins
`timescale 1ns/100ps
module comparator_model (
    // Clock for the sleep pattern
    input wire logic pclk,
    // Block side
    input wire analog_compare_pkg::analog_s analog,
    // Pin and reference voltages in millivolts
    input wire logic [11:0] pos_mv,
    input wire logic [11:0] neg_mv,
    input wire logic [11:0] bg_mv,
    output logic raw
);
    import analog_compare_pkg::*;
    logic junk_q = 1'h0;
    logic [11:0] noninv;
    always @(posedge pclk) begin
        junk_q <= ~junk_q;
    end
    // Reference taken as buffered; software turns the buffer on first
    assign noninv = analog.bandgap_select ? bg_mv : pos_mv;
    // Asleep the output means nothing, so it keeps changing to expose false events
    assign raw = analog.low_power ? junk_q : (noninv > neg_mv);
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the analog compare control block
`timescale 1ns/100ps
`include "analog_compare_cfg.svh"
module tb_top;
    import analog_compare_pkg::*;
    localparam logic [11:0] CTRL = `OFS_STATUS_CONTROL;
    // Rows: ref select, edge mode[1:0], start level, end level, flag
    localparam logic [5:0] ROWS [8] = '{6'h02, 6'h25, 6'h0B, 6'h2C, 6'h15, 6'h32, 6'h1B, 6'h3D};
    logic pclk, presetn, raw, irq, serr;
    apb_req_s req;
    apb_rsp_s rsp;
    power_mode_e pm;
    analog_s an;
    logic [11:0] vneg;
    logic [31:0] rd, c;
    int err_count, n_compared, cyc;

    analog_compare_ctrl dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .power_mode(pm), .comparator_raw(raw), .analog(an), .irq(irq));
    comparator_model model_u (.pclk(pclk), .analog(an), .pos_mv(12'h258), .neg_mv(vneg),
        .bg_mv(12'h12C), .raw(raw));

    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'h1;
        @(posedge pclk);
        req.penable <= 1'h1;
        // The wait ends on the first edge that sees pready high
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'h1);
        rd = rsp.prdata;
        serr = rsp.pslverr;
        req.psel <= 1'h0;
        req.penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'h1, d);
    endtask
    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'h0, 32'h0);
        chk(nm, e, rd);
    endtask
    // Settle time covers the four-edge path to the live bit
    task automatic lvl(input logic h);
        @(posedge pclk);
        vneg <= h ? 12'h064 : 12'h320;
        repeat (6) @(posedge pclk);
    endtask
    task automatic mode(input power_mode_e m);
        @(posedge pclk);
        pm <= m;
    endtask
    task automatic ck_irq(input logic e);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic ck_pin(input logic [1:0] e);
        @(negedge pclk);
        chk("pin", {30'h0, e}, {30'h0, an.compare_output, an.compare_output_oe});
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'h0;
        req = '0;
        pm = PM_RUN;
        vneg = 12'h320;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        rdchk("ctrl reset", CTRL, 32'h0);
        rdchk("irq enable reset", `OFS_IRQ_ENABLE, 32'h0);
        bus(12'h010, 1'h0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, serr});
        foreach (ROWS[i]) begin
            c = {24'h0, 1'h1, ROWS[i][5], 4'h0, ROWS[i][4:3]};
            wr(CTRL, c | 32'h20);
            lvl(ROWS[i][2]);
            wr(CTRL, c | 32'h20);
            lvl(ROWS[i][1]);
            rdchk("edge row", CTRL, c | {26'h0, ROWS[i][0], 1'h0, ROWS[i][1], 3'h0});
        end
        // Mid voltage sits between the pin and the bandgap
        wr(CTRL, 32'hA0);
        @(posedge pclk);
        vneg <= 12'h1C2;
        repeat (6) @(posedge pclk);
        rdchk("pin source", CTRL, 32'h88);
        // Bandgap buffer taken as already on before this select
        wr(CTRL, 32'hC0);
        repeat (6) @(posedge pclk);
        rdchk("bandgap source", CTRL, 32'hE0);
        wr(CTRL, 32'hB3);
        wr(CTRL, 32'hB3);
        ck_irq(1'h0);
        lvl(1'h0);
        ck_irq(1'h1);
        rdchk("irq status", `OFS_IRQ_STATUS, 32'h1);
        wr(CTRL, 32'h93);
        ck_irq(1'h1);
        wr(CTRL, 32'hB3);
        ck_irq(1'h0);
        wr(CTRL, 32'h83);
        lvl(1'h1);
        ck_irq(1'h0);
        wr(`OFS_IRQ_ENABLE, 32'h1);
        ck_irq(1'h1);
        wr(`OFS_IRQ_CLEAR, 32'h1);
        ck_irq(1'h0);
        wr(`OFS_IRQ_ENABLE, 32'h0);
        wr(CTRL, 32'h84);
        ck_pin(2'h3);
        wr(CTRL, 32'h80);
        ck_pin(2'h2);
        wr(CTRL, 32'h23);
        lvl(1'h0);
        lvl(1'h1);
        rdchk("disabled", CTRL, 32'h03);
        ck_pin(2'h0);
        wr(CTRL, 32'hB3);
        repeat (6) @(posedge pclk);
        wr(CTRL, 32'hB3);
        mode(PM_WAIT);
        lvl(1'h0);
        ck_irq(1'h1);
        mode(PM_MID_STOP);
        lvl(1'h1);
        lvl(1'h0);
        ck_irq(1'h0);
        chk("low power", 32'h1, {31'h0, an.low_power});
        mode(PM_RUN);
        repeat (6) @(posedge pclk);
        ck_irq(1'h1);
        rdchk("after mid stop", CTRL, 32'hB3);
        mode(PM_DEEP_STOP);
        repeat (3) @(posedge pclk);
        mode(PM_RUN);
        rdchk("after deep stop", CTRL, 32'h0);
        // Reset while in mid stop must leave reset values
        wr(CTRL, 32'h94);
        mode(PM_MID_STOP);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        mode(PM_RUN);
        rdchk("mid stop reset", CTRL, 32'h0);
        give_verdict();
    end
endmodule
